// *** hw/as2_ctrl.sv ***
// Purpose: Host controller driving a 2M x 2 asynchronous static memory.
// Assumes: 40 MHz core_clk; memory pins need no clock.
// Notes: One request at a time; reads return true data and a pair check.
//
// Contract
// - Read keeps store strobe high while selected.
// - Read address held for full cycle time.
// - Address valid no later than select falling.
// - Store pulse and data setup meet width.
// - Write address stable before write ends.
// - Select low no later than store falling.
// - Write cycle lasts at least cycle time.
`timescale 1ns/1ps
module as2_ctrl (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [20:0] req_index,
  input wire logic [1:0] req_data,
  output logic req_ready,
  output logic rsp_valid,
  output logic [1:0] rsp_data,
  output logic rsp_error,
  output logic [20:0] word_index,
  output logic sel_n,
  output logic store_n,
  output logic [1:0] input_bits,
  input wire logic [1:0] output_bits,
  input wire logic [1:0] output_bits_n
);
  // Synchronised read data from the pin stage
  as2_smp_if smp ();

  as2_sync u_sync (
    .core_clk(core_clk),
    .rstn(rstn),
    .output_bits(output_bits),
    .output_bits_n(output_bits_n),
    .smp(smp.src)
  );

  as2_pkg::as2_state_t state;      // Current controller state
  as2_pkg::as2_state_t next_state; // Following state
  logic [3:0] cnt;                 // Wait counter
  logic [3:0] next_cnt;
  logic next_ready;
  logic next_rsp_valid;
  logic [1:0] next_rsp_data;
  logic next_rsp_error;
  logic [20:0] next_index;
  logic next_sel_n;
  logic next_store_n;
  logic [1:0] next_din;

  // Request accepted this cycle
  wire take_req = req_ready && req_valid;
  // Wait counter has run out
  wire cnt_done = (cnt == 4'h0);
  // Complement pair agrees
  wire pair_ok = (smp.q == ~smp.qn);
  // Counter steps down and stops at zero
  wire [3:0] cnt_dec = cnt_done ? 4'h0 : 4'(cnt - 4'h1);

  // Next-state and pin decisions
  always_comb begin
    next_state = state;
    next_cnt = cnt_dec;
    next_ready = 1'b0;
    next_rsp_valid = 1'b0;
    next_rsp_data = rsp_data;
    next_rsp_error = rsp_error;
    next_index = word_index;
    next_sel_n = sel_n;
    next_store_n = store_n;
    next_din = input_bits;
    case (state)
      as2_pkg::AS2_IDLE: begin
        // Ready until a request is taken
        next_ready = !take_req;
        if (take_req) begin
          // Address and select change together, never address later
          next_index = req_index;
          next_din = req_data;
          next_sel_n = 1'b0;
          if (req_write) begin
            next_state = as2_pkg::AS2_WR_SETUP;
          end else begin
            // Store stays high for a read
            next_cnt = as2_pkg::RD_CNT;
            next_state = as2_pkg::AS2_RD_WAIT;
          end
        end
      end
      as2_pkg::AS2_RD_WAIT: begin
        // Sample once access time and synchroniser have passed
        if (cnt_done) begin
          next_rsp_valid = 1'b1;
          next_rsp_data = smp.q;
          next_rsp_error = !pair_ok;
          next_sel_n = 1'b1;
          next_state = as2_pkg::AS2_DESEL;
        end
      end
      as2_pkg::AS2_WR_SETUP: begin
        // Select already low one cycle; now open the write
        next_store_n = 1'b0;
        next_cnt = as2_pkg::WP_CNT;
        next_state = as2_pkg::AS2_WR_PULSE;
      end
      as2_pkg::AS2_WR_PULSE: begin
        // Store rising ends the write with address and data still held
        if (cnt_done) begin
          next_store_n = 1'b1;
          next_state = as2_pkg::AS2_WR_END;
        end
      end
      as2_pkg::AS2_WR_END: begin
        // Hold address one more cycle, then deselect
        next_sel_n = 1'b1;
        next_state = as2_pkg::AS2_DESEL;
      end
      as2_pkg::AS2_DESEL: begin
        // Device idles with outputs low before the next access
        next_ready = 1'b1;
        next_state = as2_pkg::AS2_IDLE;
      end
      default: begin
        next_sel_n = 1'b1;
        next_store_n = 1'b1;
        next_state = as2_pkg::AS2_IDLE;
      end
    endcase
  end

  // State and counter
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state <= as2_pkg::AS2_IDLE;
      cnt <= 4'h0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // Memory pin drivers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      word_index <= 21'h000000;
      sel_n <= as2_pkg::RST_SEL_N;
      store_n <= as2_pkg::RST_STORE_N;
      input_bits <= 2'h0;
    end else begin
      word_index <= next_index;
      sel_n <= next_sel_n;
      store_n <= next_store_n;
      input_bits <= next_din;
    end
  end

  // User-side response and handshake
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= 2'h0;
      rsp_error <= 1'b0;
    end else begin
      req_ready <= next_ready;
      rsp_valid <= next_rsp_valid;
      rsp_data <= next_rsp_data;
      rsp_error <= next_rsp_error;
    end
  end

  // Checks on the driven pin sequences
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // Write shape: store low one cycle, then high, then deselect
  sequence wr_open_s;
    !store_n && !sel_n;
  endsequence
  sequence wr_close_s;
    ##1 (store_n && !sel_n) ##1 sel_n;
  endsequence

  read_strobe_a: assert property (
    (state == as2_pkg::AS2_RD_WAIT) |-> store_n)
    else $error("store strobe low during read");
  rd_addr_hold_a: assert property (
    $changed(word_index) |=> $stable(word_index))
    else $error("read address changed too soon");
  addr_sel_a: assert property (
    (!sel_n && !$past(sel_n)) |-> $stable(word_index))
    else $error("address moved while selected");
  wr_pulse_a: assert property (
    ($fell(store_n) ##0 wr_open_s) |-> wr_close_s
      and (##1 $stable(input_bits)))
    else $error("write pulse shape wrong");
  wr_addr_setup_a: assert property (
    $rose(store_n) |-> ($past(word_index, 2) == word_index))
    else $error("write address not held before write end");
  sel_first_a: assert property (
    $fell(store_n) |-> !$past(sel_n))
    else $error("store fell before select");
  wr_cycle_a: assert property (
    $rose(store_n) |=> $stable(word_index) ##1 $stable(word_index))
    else $error("write cycle too short");
  rd_latency_a: assert property (
    ($fell(sel_n) && state == as2_pkg::AS2_RD_WAIT) |-> ##3 rsp_valid)
    else $error("read answer not after access and sync delay");
  pair_check_a: assert property (
    (state == as2_pkg::AS2_RD_WAIT && cnt_done) |=>
      (rsp_error == ($past(smp.q) != ~$past(smp.qn))))
    else $error("pair check mismatch");
  desel_after_a: assert property (
    $rose(rsp_valid) |-> sel_n && store_n)
    else $error("device left selected after read");
endmodule : as2_ctrl

// *** hw/as2_pkg.sv ***
// Purpose: Shared constants and types for the two-bit static memory host.
// Assumes: Core clock of 40 MHz; slow-grade memory timing is honoured.
// Notes: Every cycle count derives from a time in ns and the clock period.
package as2_pkg;
  // Memory geometry
  localparam int unsigned IDX_W = 21;           // Word index width
  localparam int unsigned DAT_W = 2;            // Bits per word
  localparam int unsigned DEPTH = 2097152;      // Number of words
  // Clock period in picoseconds
  localparam int unsigned CLK_PS = 25000;
  // Device and host timing, slow grade, in ns
  localparam int unsigned T_ACC_NS = 15;        // Address or select access
  localparam int unsigned T_WP_NS = 9;          // Least store pulse width
  localparam int unsigned T_AW_NS = 10;         // Address valid to write end
  // Least times round up to whole cycles, never below one
  localparam int unsigned ACC_CYC = (T_ACC_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned WP_CYC = (T_WP_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned AW_CYC = (T_AW_NS * 1000 + CLK_PS - 1) / CLK_PS;
  // Synchroniser depth on the returned data pins
  localparam int unsigned SYNC_STAGES = 2;
  // Counter width and preload values
  localparam int unsigned CNT_W = 4;
  localparam logic [3:0] RD_CNT = 4'(ACC_CYC + SYNC_STAGES - 1);
  localparam logic [3:0] WP_CNT = 4'(WP_CYC - 1);
  // Reset values of the pin drivers
  localparam logic RST_SEL_N = 1'b1;
  localparam logic RST_STORE_N = 1'b1;
  // Controller states
  typedef enum logic [2:0] {
    AS2_IDLE = 3'b000,
    AS2_RD_WAIT = 3'b001,
    AS2_WR_SETUP = 3'b010,
    AS2_WR_PULSE = 3'b011,
    AS2_WR_END = 3'b100,
    AS2_DESEL = 3'b101
  } as2_state_t;
endpackage : as2_pkg

// *** hw/as2_smp_if.sv ***
// Purpose: Carries synchronised read data from the pin stage to the engine.
// Assumes: Both ends run on core_clk.
// Notes: True and complement bits travel together.
`timescale 1ns/1ps
interface as2_smp_if;
  logic [1:0] q;   // Synchronised true data bits
  logic [1:0] qn;  // Synchronised complement data bits
  modport src (output q, output qn);
  modport dst (input q, input qn);
endinterface : as2_smp_if

// *** hw/as2_sync.sv ***
// Purpose: Two-flop synchroniser for the memory's returned data pins.
// Assumes: Pins are asynchronous to core_clk.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
module as2_sync (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [1:0] output_bits,
  input wire logic [1:0] output_bits_n,
  as2_smp_if.src smp
);
  // All four pins as one vector
  wire [3:0] pin_raw = {output_bits_n, output_bits};
  logic [3:0] meta;   // First stage, read only by the second
  logic [3:0] stable; // Second stage, safe to use

  // One synchroniser per pin
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pin
      always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
          meta[gi] <= 1'b0;
          stable[gi] <= 1'b0;
        end else begin
          meta[gi] <= pin_raw[gi];
          stable[gi] <= meta[gi];
        end
      end
    end
  endgenerate

  // Split back into true and complement halves
  assign smp.q = stable[1:0];
  assign smp.qn = stable[3:2];
endmodule : as2_sync

// *** testbench/as2_mem_model.sv ***
// Purpose: Behavioural 2M x 2 static memory facing the host controller.
// Assumes: Slow-grade delays; a word never written reads as zero.
// Notes: bad_pair spoils the complement pins when a scenario asks.
`timescale 1ns/1ps
module as2_mem_model #(
  parameter int ACC_NS = 15, // Address or select access time
  parameter int LOW_NS = 9   // Time to force the outputs low
) (
  input wire logic [20:0] word_index,
  input wire logic sel_n,
  input wire logic store_n,
  input wire logic [1:0] input_bits,
  input wire logic bad_pair,
  output logic [1:0] output_bits,
  output logic [1:0] output_bits_n
);
  logic [1:0] mem [int unsigned]; // Sparse word store
  int unsigned gen = 0; // Bumped on every control or address change
  initial {output_bits, output_bits_n} = 4'h0;
  // Store only while select and strobe are both low
  always @(sel_n or store_n or word_index or input_bits)
    if (sel_n === 1'b0 && store_n === 1'b0) mem[word_index] = input_bits;
  // Restart the output timing on each change; stale timers give up
  always @(sel_n or store_n or word_index) begin
    gen = gen + 1;
    fork
      settle(gen);
    join_none
  end
  // Drive the output pins after the delays of the present state
  task automatic settle(input int unsigned g);
    logic [1:0] v;
    if (sel_n !== 1'b0 || store_n !== 1'b1) begin
      // Deselected or storing: outputs low
      #(LOW_NS);
      if (g == gen) {output_bits, output_bits_n} = 4'h0;
    end else begin
      // Old word held, then junk, then the word
      #4;
      if (g == gen) {output_bits, output_bits_n} = 4'h5;
      #(ACC_NS - 4);
      v = mem.exists(word_index) ? mem[word_index] : 2'b00;
      if (g == gen) begin
        output_bits = v;
        output_bits_n = bad_pair ? v : ~v; // Complement pins
      end
    end
  endtask : settle
endmodule : as2_mem_model

// *** testbench/tb.sv ***
// Purpose: Self-checking bench for the static memory host controller.
// Assumes: The memory model answers within the slow-grade access time.
// Notes: Reads queue their expected word; a monitor pops on each answer.
`timescale 1ns/1ps
module tb;
  logic core_clk = 1'b0; // 40 MHz clock
  logic rstn = 1'b0; // Reset, active low
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [20:0] req_index = 21'h0;
  logic [1:0] req_data = 2'h0;
  logic bad_pair = 1'b0; // Spoils the complement pins in the model
  logic req_ready, rsp_valid, rsp_error, sel_n, store_n;
  logic [1:0] rsp_data, input_bits, output_bits, output_bits_n;
  logic [20:0] word_index;
  logic [2:0] exp_q [$]; // Expected {error, data} of pending reads
  logic [1:0] shadow [int unsigned]; // Words the bench has written
  logic [31:0] lfsr = 32'h77ba;
  int bad_count = 0;
  int check_count = 0;
  always #12.5 core_clk = ~core_clk;
  as2_ctrl DUT (.core_clk(core_clk), .rstn(rstn), .req_valid(req_valid),
    .req_write(req_write), .req_index(req_index), .req_data(req_data),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_error(rsp_error), .word_index(word_index), .sel_n(sel_n),
    .store_n(store_n), .input_bits(input_bits),
    .output_bits(output_bits), .output_bits_n(output_bits_n));
  as2_mem_model mem_model (.word_index(word_index), .sel_n(sel_n),
    .store_n(store_n), .input_bits(input_bits), .bad_pair(bad_pair),
    .output_bits(output_bits), .output_bits_n(output_bits_n));
  // Next pseudo-random value
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : next_rand
  // Count a comparison and report a mismatch
  task automatic compare(input string what, input logic [2:0] exp,
                         input logic [2:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : compare
  // Print the verdict and stop
  task automatic summarize();
    if (bad_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  // Wait for ready, then hold one request until its taking edge
  task automatic do_req(input logic w, input logic [20:0] idx,
                        input logic [1:0] d, input logic e);
    int n;
    n = 0;
    while (req_ready !== 1'b1) begin
      @(posedge core_clk);
      #1;
      n++;
      if (n > 20) begin
        compare("req_ready", 3'h1, {2'b00, req_ready});
        summarize();
      end
    end
    req_valid = 1'b1;
    req_write = w;
    req_index = idx;
    req_data = d;
    bad_pair = e;
    if (w) shadow[idx] = d;
    else exp_q.push_back({e, shadow.exists(idx) ? shadow[idx] : 2'b00});
    @(posedge core_clk);
    #1;
    req_valid = 1'b0;
  endtask : do_req
  // Take the oldest note on each answer and compare; watch the strobes
  always @(posedge core_clk) begin
    if (rstn === 1'b1 && rsp_valid !== 1'b0) begin
      if (exp_q.size() == 0) begin
        // Answer with no read outstanding
        compare("rsp_valid", 3'h0, {2'b00, rsp_valid});
      end else begin
        // Word and pair flag of the oldest read
        compare("rsp", exp_q.pop_front(), {rsp_error, rsp_data});
      end
    end
    if (store_n === 1'b0) compare("sel_n", 3'h0, {2'b00, sel_n});
  end
  // Cut a hang short
  initial begin
    #200us;
    bad_count++;
    summarize();
  end
  // Main sequence
  initial begin
    logic [20:0] list [$];
    int n;
    repeat (3) @(posedge core_clk);
    compare("reset", 3'b011, {req_ready, sel_n, store_n});
    #1;
    rstn = 1'b1;
    // Both ends of the word array
    do_req(1'b1, 21'h0, 2'b10, 1'b0);
    do_req(1'b1, 21'h1fffff, 2'b01, 1'b0);
    do_req(1'b0, 21'h0, 2'b00, 1'b0);
    do_req(1'b0, 21'h1fffff, 2'b00, 1'b0);
    // Every data value, then an overwrite of one word
    for (n = 0; n < 4; n++) begin
      do_req(1'b1, 21'(n + 'h155), n[1:0], 1'b0);
    end
    do_req(1'b1, 21'h155, 2'b11, 1'b0);
    for (n = 0; n < 4; n++) begin
      do_req(1'b0, 21'(n + 'h155), 2'b00, 1'b0);
    end
    // Random words written, then read back to back
    repeat (12) begin
      lfsr = next_rand(lfsr);
      list.push_back(lfsr[20:0]);
      do_req(1'b1, lfsr[20:0], lfsr[22:21], 1'b0);
    end
    foreach (list[i]) do_req(1'b0, list[i], 2'b00, 1'b0);
    // Complement pins broken, then healthy again
    do_req(1'b0, 21'h0, 2'b00, 1'b1);
    do_req(1'b0, 21'h0, 2'b00, 1'b0);
    n = 0;
    while (exp_q.size() != 0 && n < 20) begin
      @(posedge core_clk);
      n++;
    end
    if (exp_q.size() != 0) compare("pending", 3'h0, 3'h1);
    summarize();
  end
endmodule : tb
